/* adc_cfg_pkg.sv */
// Constants for the converter configuration register bank.
// Assumes a 32-bit APB master; register indices map to byte address index*4.
package adc_cfg_pkg;

    // ----------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [7:0] AVG_POWERDOWN_CTRL_IDX = 8'hC4;
    localparam logic [7:0] LANE_CLOCK_CFG_IDX = 8'hC5;
    localparam logic [7:0] BRINGUP_CTRL_A_IDX = 8'hF4;
    localparam logic [7:0] BRINGUP_CTRL_B_IDX = 8'hF6;
    localparam logic [7:0] DOWNCONVERT_CTRL_IDX = 8'hFB;
    localparam logic [7:0] OSC_PHASE_LOW_IDX = 8'hFC;
    localparam int NUM_REGS = 6;
    localparam int REG_W = 16;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ----------------------------------------
    // Storage slots
    // ----------------------------------------
    localparam int SLOT_AVG = 0;
    localparam int SLOT_LANE = 1;
    localparam int SLOT_BRING_A = 2;
    localparam int SLOT_BRING_B = 3;
    localparam int SLOT_DDC = 4;
    localparam int SLOT_PHASE = 5;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SLEEP_BIT = 0;
    localparam int AVG_SINGLE_BIT = 1;
    localparam int AVG_PAIR_LSB = 4;
    localparam int LANE_CLK_BIT = 9;
    localparam int BRINGUP_BIT = 1;
    localparam int MIXER_BIT = 0;
    localparam int XOR_SRC_BIT = 2;
    localparam int PERIODIC_BIT = 3;

    // Scrambler pseudo-random generator
    localparam int PRBS_W = 7;
    localparam logic [6:0] PRBS_SEED = 7'h7F;

endpackage

/* adc_config_register_bank.sv */
// Configuration register bank with oscillator sync and output scrambler.
// Assumes an APB master on CLOCK; the sample-sync pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: Full-chip sleep bit high powers the device down, low lets it run.
// RULE_02: Software writes the averaging pair field as 0 to disable or 2 to enable averaging.
// RULE_03: Software writes the single averaging bit as 0 when disabled and 1 when enabled.
// RULE_04: Software sets the lane clock bit to 0 for lane setting 0 or 2, 1 for 5 or 7.
// RULE_05: Software writes the first bring-up bit 1 during start-up, then 0.
// RULE_06: Software writes the second bring-up bit 1 during start-up, then 0.
// RULE_07: Software sets the periodic sync select bit when the sync pin gets a pulse train.
// RULE_08: With periodic select low, each sync pin pulse resynchronises the oscillator.
// RULE_09: With periodic select high, only the first pulse of a train resynchronises it.
// RULE_10: Scrambling with source 0 appends a PRBS bit after the LSB and XORs data with it.
// RULE_11: Scrambling with source 1 XORs the data with the conversion result LSB.
// RULE_12: Down-converter control bit 0 enables the down converter.
// RULE_13: Software keeps reserved fields at zero.
// RULE_14: The phase register holds the low part of the oscillator phase word.
// RULE_15: Every register reads back its last written value and resets to zero.
module adc_config_register_bank
    import adc_cfg_pkg::*;
#(
    parameter int DATA_W = 18
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_SYNC_PIN,
    input wire logic SCRAMBLE_EN,
    input wire logic CONV_VALID,
    input wire logic [DATA_W-1:0] CONV_DATA,
    output logic [DATA_W:0] SCRAMBLED_DATA,
    output logic SCRAMBLED_VALID,
    output logic OSC_SYNC,
    output logic FULL_CHIP_SLEEP,
    output logic DOWNCONVERTER_ON,
    output logic [15:0] OSC_PHASE_WORD,
    output logic LANE_CLOCK_SELECT,
    output logic [1:0] AVG_SETUP_PAIR,
    output logic AVG_SETUP_SINGLE,
    output logic [1:0] BRINGUP_BITS
);

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    logic [15:0] regs_reg [NUM_REGS];
    logic [15:0] regs_next [NUM_REGS];
    logic [2:0] slot;
    logic hit;
    logic wr_acc;
    logic rd_acc;

    // Index to slot decode; unmapped addresses raise PSLVERR
    always_comb
    begin
        slot = 3'd0;
        hit = 1'b1;
        if (PADDR == {2'b00, AVG_POWERDOWN_CTRL_IDX, 2'b00})
            slot = 3'(SLOT_AVG);
        else if (PADDR == {2'b00, LANE_CLOCK_CFG_IDX, 2'b00})
            slot = 3'(SLOT_LANE);
        else if (PADDR == {2'b00, BRINGUP_CTRL_A_IDX, 2'b00})
            slot = 3'(SLOT_BRING_A);
        else if (PADDR == {2'b00, BRINGUP_CTRL_B_IDX, 2'b00})
            slot = 3'(SLOT_BRING_B);
        else if (PADDR == {2'b00, DOWNCONVERT_CTRL_IDX, 2'b00})
            slot = 3'(SLOT_DDC);
        else if (PADDR == {2'b00, OSC_PHASE_LOW_IDX, 2'b00})
            slot = 3'(SLOT_PHASE);
        else
            hit = 1'b0;
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign wr_acc = PSEL && PENABLE && PWRITE && hit;
    assign rd_acc = PSEL && PENABLE && !PWRITE && hit;
    assign PSLVERR = PSEL && PENABLE && !hit;

    logic [31:0] rdata_reg, rdata_next;

    // Read word latched at the end of setup; keeps PRDATA off the decode
    // path without costing a wait state
    always_comb
    begin
        rdata_next = rdata_reg;
        if (PSEL && !PENABLE)
            rdata_next = hit ? {16'h0000, regs_reg[slot]} : 32'h0000_0000;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rdata_next;
    end

    assign PRDATA = rdata_reg;

    // Full 16 bits stored so reserved bits read back as written
    generate
        for (genvar i = 0; i < NUM_REGS; i++)
        begin : g_reg
            always_comb
            begin
                regs_next[i] = regs_reg[i];
                if (wr_acc && slot == 3'(i))
                    regs_next[i] = PWDATA[15:0]; // RULE_15
            end

            always_ff @(posedge CLOCK or posedge RST)
            begin
                if (RST)
                    regs_reg[i] <= REG_RESET; // RULE_15
                else
                    regs_reg[i] <= regs_next[i];
            end
        end
    endgenerate

    // Control fields driven straight from storage; DOWNCONVERTER_ON is also gated off by sleep
    assign FULL_CHIP_SLEEP = regs_reg[SLOT_AVG][SLEEP_BIT]; // RULE_01
    assign AVG_SETUP_PAIR = regs_reg[SLOT_AVG][AVG_PAIR_LSB+1:AVG_PAIR_LSB];
    assign AVG_SETUP_SINGLE = regs_reg[SLOT_AVG][AVG_SINGLE_BIT];
    assign LANE_CLOCK_SELECT = regs_reg[SLOT_LANE][LANE_CLK_BIT];
    assign BRINGUP_BITS = {regs_reg[SLOT_BRING_B][BRINGUP_BIT],
                           regs_reg[SLOT_BRING_A][BRINGUP_BIT]};
    assign DOWNCONVERTER_ON = regs_reg[SLOT_DDC][MIXER_BIT] && !FULL_CHIP_SLEEP; // RULE_12 RULE_01
    assign OSC_PHASE_WORD = regs_reg[SLOT_PHASE]; // RULE_14

    logic periodic_sel;
    logic xor_src;
    assign periodic_sel = regs_reg[SLOT_DDC][PERIODIC_BIT];
    assign xor_src = regs_reg[SLOT_DDC][XOR_SRC_BIT];

    // ----------------------------------------
    // Sample-sync pin and oscillator sync
    // ----------------------------------------
    logic s1_reg, s2_reg, s3_reg;
    logic level_reg, level_next;
    logic armed_reg, armed_next;
    logic sync_reg, sync_next;
    logic pin_rise;
    logic ddc_write;

    // Level moves only once two late stages agree
    assign pin_rise = (s2_reg == s3_reg) && s2_reg && !level_reg;
    assign ddc_write = wr_acc && slot == 3'(SLOT_DDC);

    // Writing the control register rearms the first-pulse catcher
    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s2_reg : level_reg;
        armed_next = armed_reg;
        sync_next = 1'b0;
        if (pin_rise && DOWNCONVERTER_ON)
        begin
            if (!periodic_sel)
                sync_next = 1'b1; // RULE_08
            else if (armed_reg)
            begin
                sync_next = 1'b1; // RULE_09
                armed_next = 1'b0; // RULE_09
            end
        end
        if (ddc_write)
            armed_next = 1'b1;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            armed_reg <= 1'b1;
            sync_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= SAMPLE_SYNC_PIN;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            armed_reg <= armed_next;
            sync_reg <= sync_next;
        end
    end

    assign OSC_SYNC = sync_reg;

    // ----------------------------------------
    // Output scrambler
    // ----------------------------------------
    logic [PRBS_W-1:0] prbs_reg, prbs_next;
    logic [DATA_W:0] out_reg, out_next;
    logic vld_reg, vld_next;

    // PRBS7 advances once per accepted sample; sleep freezes the output
    always_comb
    begin
        prbs_next = prbs_reg;
        out_next = out_reg;
        vld_next = 1'b0;
        if (CONV_VALID && !FULL_CHIP_SLEEP) // RULE_01
        begin
            vld_next = 1'b1;
            prbs_next = {prbs_reg[PRBS_W-2:0], prbs_reg[6] ^ prbs_reg[5]};
            if (!SCRAMBLE_EN)
                out_next = {CONV_DATA, 1'b0};
            else if (!xor_src)
                out_next = {CONV_DATA ^ {DATA_W{prbs_reg[0]}}, prbs_reg[0]}; // RULE_10
            else
                out_next = {CONV_DATA ^ {DATA_W{CONV_DATA[0]}}, CONV_DATA[0]}; // RULE_11
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            prbs_reg <= PRBS_SEED;
            out_reg <= '0;
            vld_reg <= 1'b0;
        end
        else
        begin
            prbs_reg <= prbs_next;
            out_reg <= out_next;
            vld_reg <= vld_next;
        end
    end

    assign SCRAMBLED_DATA = out_reg;
    assign SCRAMBLED_VALID = vld_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sleep_write_a: assert property (wr_acc && slot == 3'(SLOT_AVG) |=> // RULE_01
        FULL_CHIP_SLEEP == $past(PWDATA[0]))
        else $error("sleep bit not taken from write");
    sleep_quiet_a: assert property (FULL_CHIP_SLEEP |=> !OSC_SYNC && !SCRAMBLED_VALID) // RULE_01
        else $error("activity while asleep");
    mixer_enable_a: assert property (ddc_write && !FULL_CHIP_SLEEP |=> // RULE_12
        DOWNCONVERTER_ON == $past(PWDATA[0]))
        else $error("mixer enable wrong");
    single_sync_a: assert property (pin_rise && DOWNCONVERTER_ON && !periodic_sel |=> // RULE_08
        OSC_SYNC)
        else $error("single pulse not synced");
    periodic_once_a: assert property (OSC_SYNC && periodic_sel && !$past(ddc_write) // RULE_09
        |-> !armed_reg)
        else $error("periodic sync left armed");
    periodic_ignore_a: assert property (periodic_sel && !armed_reg && !ddc_write |=> // RULE_09
        !OSC_SYNC)
        else $error("later pulse resynced");
    prbs_xor_a: assert property (CONV_VALID && !FULL_CHIP_SLEEP && SCRAMBLE_EN // RULE_10
        && !xor_src
        |=> SCRAMBLED_DATA == {$past(CONV_DATA) ^ {DATA_W{$past(prbs_reg[0])}},
        $past(prbs_reg[0])})
        else $error("prbs scramble wrong");
    lsb_xor_a: assert property (CONV_VALID && !FULL_CHIP_SLEEP && SCRAMBLE_EN && xor_src // RULE_11
        |=> SCRAMBLED_DATA[DATA_W:1] == ($past(CONV_DATA) ^ {DATA_W{$past(CONV_DATA[0])}}))
        else $error("lsb scramble wrong");
    phase_word_a: assert property (wr_acc && slot == 3'(SLOT_PHASE) |=> // RULE_14
        OSC_PHASE_WORD == $past(PWDATA[15:0]))
        else $error("phase word not updated");
    read_back_a: assert property (wr_acc |=> // RULE_15
        regs_reg[$past(slot)] == $past(PWDATA[15:0]))
        else $error("written word not stored");

    periodic_sync_c: cover property (periodic_sel && OSC_SYNC);
    prbs_out_c: cover property (SCRAMBLED_VALID && SCRAMBLE_EN && !xor_src);
    sleep_c: cover property ($rose(FULL_CHIP_SLEEP));
    unmapped_c: cover property (PSLVERR);

endmodule
`default_nettype wire

/* adc_config_register_bank_tb.sv */
// Self-checking bench for the converter configuration register bank.
// Assumes the bank answers APB itself; the bench drives every other input.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb
    import adc_cfg_pkg::*;
;
    logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic SAMPLE_SYNC_PIN = 0, SCRAMBLE_EN = 0, CONV_VALID = 0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [17:0] CONV_DATA = '0, d;
    logic [6:0] pm = PRBS_SEED;
    logic [18:0] SCRAMBLED_DATA;
    logic [15:0] OSC_PHASE_WORD;
    logic [1:0] AVG_SETUP_PAIR, BRINGUP_BITS;
    logic PREADY, PSLVERR, SCRAMBLED_VALID, OSC_SYNC, FULL_CHIP_SLEEP, er;
    logic DOWNCONVERTER_ON, LANE_CLOCK_SELECT, AVG_SETUP_SINGLE;
    int err_total = 0, samples_checked = 0, seed = 32'h2fbb, hits, i;
    logic [15:0] mdl [6];
    localparam logic [7:0] IDX [6] = '{AVG_POWERDOWN_CTRL_IDX, LANE_CLOCK_CFG_IDX,
        BRINGUP_CTRL_A_IDX, BRINGUP_CTRL_B_IDX, DOWNCONVERT_CTRL_IDX, OSC_PHASE_LOW_IDX};
    // Writable fields only, so reserved bits stay zero
    localparam logic [15:0] MSK [6] = '{16'h0023, 16'h0200, 16'h0002, 16'h0002,
        16'h000D, 16'hFFFF};

    // Free-running 100 MHz clock
    always #5 CLOCK = ~CLOCK;

    adc_config_register_bank dut_u (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SAMPLE_SYNC_PIN(SAMPLE_SYNC_PIN), .SCRAMBLE_EN(SCRAMBLE_EN),
        .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA), .SCRAMBLED_DATA(SCRAMBLED_DATA),
        .SCRAMBLED_VALID(SCRAMBLED_VALID), .OSC_SYNC(OSC_SYNC),
        .FULL_CHIP_SLEEP(FULL_CHIP_SLEEP), .DOWNCONVERTER_ON(DOWNCONVERTER_ON),
        .OSC_PHASE_WORD(OSC_PHASE_WORD), .LANE_CLOCK_SELECT(LANE_CLOCK_SELECT),
        .AVG_SETUP_PAIR(AVG_SETUP_PAIR), .AVG_SETUP_SINGLE(AVG_SETUP_SINGLE),
        .BRINGUP_BITS(BRINGUP_BITS));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; no wait count assumed, bounded for hangs
    task apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= {2'b00, idx, 2'b00};
        PWDATA <= {16'h0000, wd};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            err_total++;
            test_done;
        end
    endtask

    task wr_reg(input int k, input logic [15:0] v);
        apb(1'b1, IDX[k], v);
        mdl[k] = v;
    endtask

    task rd_all;
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b0, IDX[k], 16'h0000);
            chk(rd, {16'h0000, mdl[k]});
            chk(er, 0);
        end
    endtask

    // Output pins against the register model, one edge after the write
    task chk_outs;
        @(posedge CLOCK);
        #1;
        chk({FULL_CHIP_SLEEP, AVG_SETUP_PAIR, AVG_SETUP_SINGLE, LANE_CLOCK_SELECT,
            BRINGUP_BITS, DOWNCONVERTER_ON, OSC_PHASE_WORD}, {mdl[0][0], mdl[0][5:4],
            mdl[0][1], mdl[1][9], mdl[3][1], mdl[2][1], mdl[4][0] & ~mdl[0][0], mdl[5]});
    endtask

    // Pin high 3 cycles, low 9; counts oscillator resync pulses
    task pulse(input int exp_n);
        hits = 0;
        for (int c = 0; c < 12; c++)
        begin
            @(posedge CLOCK);
            SAMPLE_SYNC_PIN <= (c < 3);
            #1;
            if (OSC_SYNC === 1'b1)
                hits++;
        end
        chk(hits, exp_n);
    endtask

    // Mode 0 plain, 1 appended PRBS bit, 2 result LSB, 3 asleep
    task samp(input int mode);
        d = 18'($random(seed));
        @(posedge CLOCK);
        CONV_VALID <= 1'b1;
        CONV_DATA <= d;
        @(posedge CLOCK);
        CONV_VALID <= 1'b0;
        #1;
        chk(SCRAMBLED_VALID, mode != 3);
        if (mode == 0)
            chk(SCRAMBLED_DATA, {d, 1'b0});
        if (mode == 1)
            chk(SCRAMBLED_DATA, {d ^ {18{pm[0]}}, pm[0]});
        // Model generator steps once per accepted sample, x^7+x^6+1
        if (mode != 3)
            pm = {pm[5:0], pm[6] ^ pm[5]};
        if (mode == 2)
            chk(SCRAMBLED_DATA, {d ^ {18{d[0]}}, d[0]});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        for (i = 0; i < 6; i++)
            mdl[i] = 16'h0000;
        repeat (3) @(posedge CLOCK);
        RST <= 1'b0;
        rd_all;
        chk_outs;
        for (int r = 0; r < 4; r++)
        begin
            for (i = 0; i < 6; i++)
                wr_reg(i, 16'($random(seed)) & MSK[i]);
            chk_outs;
            rd_all;
        end
        // Unmapped word: refused, nothing stored, reads zero
        apb(1'b1, 8'hC6, 16'hFFFF);
        chk(er, 1);
        apb(1'b0, 8'hC6, 16'h0000);
        chk(er, 1);
        chk(rd, 32'h0000_0000);
        rd_all;
        // Mid-run reset must clear every written register
        @(posedge CLOCK);
        RST <= 1'b1;
        @(posedge CLOCK);
        RST <= 1'b0;
        for (i = 0; i < 6; i++)
            mdl[i] = 16'h0000;
        rd_all;
        chk_outs;
        wr_reg(0, 16'h0000);
        wr_reg(4, 16'h0001);
        pulse(1);
        pulse(1);
        wr_reg(4, 16'h0009);
        pulse(1);
        pulse(0);
        wr_reg(4, 16'h0008);
        pulse(0);
        wr_reg(4, 16'h0005);
        SCRAMBLE_EN <= 1'b1;
        repeat (4) samp(2);
        wr_reg(4, 16'h0001);
        repeat (4) samp(1);
        SCRAMBLE_EN <= 1'b0;
        repeat (2) samp(0);
        wr_reg(0, 16'h0001);
        chk_outs;
        samp(3);
        pulse(0);
        test_done;
    end
endmodule
`default_nettype wire
